/* File: bet_pkg.sv */
// Constants, register map and shared types for the burst, echo and timing control block
package bet_pkg;

	// System clock period and the time units that the counters are built on
	localparam int CLK_PERIOD_NS   = 100;
	localparam int TICK_1US_NS     = 1000;
	localparam int TICK_2US_NS     = 2000;
	localparam int TICK_16US_NS    = 16000;
	localparam int FAULT_SHORT_NS  = 1000;
	localparam int FAULT_LONG_NS   = 2000;

	// Cycle counts, least times rounded up
	localparam int CYC_1US         = (TICK_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_2US         = (TICK_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_16US        = (TICK_16US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_FAULT_SHORT = (FAULT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_FAULT_LONG  = (FAULT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register offsets
	localparam logic [7:0] ADDR_ON_FIRST_HI    = 8'ha6;
	localparam logic [7:0] ADDR_ON_FIRST_LO    = 8'ha7;
	localparam logic [7:0] ADDR_OFF_FIRST_HI   = 8'ha9;
	localparam logic [7:0] ADDR_OFF_FIRST_LO   = 8'haa;
	localparam logic [7:0] ADDR_ON_SECOND_HI   = 8'hab;
	localparam logic [7:0] ADDR_ON_SECOND_LO   = 8'hac;
	localparam logic [7:0] ADDR_OFF_SECOND_HI  = 8'had;
	localparam logic [7:0] ADDR_OFF_SECOND_LO  = 8'hae;
	localparam logic [7:0] ADDR_PULSE_FIRST    = 8'haf;
	localparam logic [7:0] ADDR_PULSE_SECOND   = 8'hb1;
	localparam logic [7:0] ADDR_DEAD_TIME      = 8'hb2;
	localparam logic [7:0] ADDR_BURST_MODE     = 8'hb3;
	localparam logic [7:0] ADDR_SAT_DEGLITCH   = 8'hb5;
	localparam logic [7:0] ADDR_SAT_TIME       = 8'hb6;
	localparam logic [7:0] ADDR_RX_FAULT_CTRL  = 8'hb7;
	localparam logic [7:0] ADDR_BLANKING       = 8'hb9;
	localparam logic [7:0] ADDR_TIMER_HI       = 8'hba;
	localparam logic [7:0] ADDR_TIMER_LO       = 8'hbb;
	localparam logic [7:0] ADDR_STATUS_SECOND  = 8'hc2;
	localparam logic [7:0] ADDR_ENABLE_CTRL    = 8'hc8;

	// Register reset value
	localparam logic [7:0] REG_RESET           = 8'h00;

	// Receive and fault control fields
	localparam int CTL_SAT_SEL_LSB  = 0;
	localparam int CTL_GAIN_LSB     = 2;
	localparam int CTL_FAULT_EN     = 4;
	localparam int CTL_FAULT_TSEL   = 5;

	// Enable control fields
	localparam int EN_BURST         = 0;
	localparam int EN_ECHO          = 1;
	localparam int EN_SAT           = 2;
	localparam int EN_CAPTURE       = 3;

	// Second status fields
	localparam int STAT_SAT_DONE    = 0;
	localparam int STAT_FAULT_FIRST = 1;

	// Burst configurations
	typedef enum logic [2:0] {
		MODE_FIRST_ONLY  = 3'h0,
		MODE_SECOND_ONLY = 3'h1,
		MODE_PUSH_PULL   = 3'h2,
		MODE_PARALLEL    = 3'h3,
		MODE_SEQUENCE    = 3'h4
	} bet_mode_type;

	// Processor special-function register access
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bet_sfr_req_type;

	// Timing of one drive channel
	typedef struct packed {
		logic [5:0]  count;
		logic [15:0] on_time;
		logic [15:0] off_time;
		logic [7:0]  dead;
	} bet_pulse_cfg_type;

endpackage

/* File: bet_pulser.sv */
// Pulse train generator for one low-side drive output
`timescale 1ns/1ns
module bet_pulser import bet_pkg::*; (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire bet_pulse_cfg_type cfg,
	output logic                   drive,
	output logic                   busy
);

	typedef enum logic [1:0] {
		PULSE_IDLE = 2'b00,
		PULSE_HIGH = 2'b01,
		PULSE_LOW  = 2'b10
	} bet_pulse_phase_type;

	typedef struct packed {
		bet_pulse_phase_type phase;
		logic [5:0]          left;
		logic [16:0]         timer;
		logic                drive;
	} bet_pulser_state_type;

	bet_pulser_state_type st;
	bet_pulser_state_type next_st;
	logic [16:0]          high_len;
	logic [16:0]          low_len;
	logic [16:0]          low_load;

	// Dead time comes off the end of the high interval and lengthens the low one
	assign high_len = (cfg.on_time > 16'(cfg.dead)) ?
		17'(cfg.on_time - 16'(cfg.dead)) : 17'h00000;
	assign low_len  = 17'(cfg.off_time) + 17'(cfg.dead);
	assign low_load = (low_len == 17'h00000) ? 17'h00000 : low_len - 17'h00001;

	always_comb begin
		next_st = st;
		unique case (st.phase)
			PULSE_IDLE: begin
				next_st.drive = 1'b0;
				if (start && cfg.count != 6'h00) begin
					next_st.left = cfg.count;
					if (high_len != 17'h00000) begin
						next_st.phase = PULSE_HIGH;
						next_st.timer = high_len - 17'h00001;
						next_st.drive = 1'b1;
					end else begin
						next_st.phase = PULSE_LOW;
						next_st.timer = low_load;
					end
				end
			end
			PULSE_HIGH: begin
				if (st.timer == 17'h00000) begin
					next_st.phase = PULSE_LOW;
					next_st.timer = low_load;
					next_st.drive = 1'b0;
				end else begin
					next_st.timer = st.timer - 17'h00001;
				end
			end
			PULSE_LOW: begin
				if (st.timer != 17'h00000) begin
					next_st.timer = st.timer - 17'h00001;
				end else if (st.left == 6'h01) begin
					next_st.phase = PULSE_IDLE;
				end else begin
					next_st.left = st.left - 6'h01;
					if (high_len != 17'h00000) begin
						next_st.phase = PULSE_HIGH;
						next_st.timer = high_len - 17'h00001;
						next_st.drive = 1'b1;
					end else begin
						next_st.timer = low_load;
					end
				end
			end
			default: begin
				next_st.phase = PULSE_IDLE;
				next_st.drive = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign drive = st.drive;
	assign busy  = (st.phase != PULSE_IDLE);

endmodule

/* File: bet_burst_echo_timing.sv */
// Burst, saturation, driver fault, blanking and free-running timer control
`timescale 1ns/1ns
module bet_burst_echo_timing import bet_pkg::*; (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire bet_sfr_req_type sfr_req,
	output logic [7:0]           sfr_rdata,
	input  wire logic            limiter_envelope_pin,
	input  wire logic [1:0]      gate_above_limit,
	input  wire logic [1:0]      drain_above_limit,
	output logic                 drive_output_first,
	output logic                 drive_output_second,
	output logic [1:0]           saturation_threshold_sel,
	output logic [1:0]           amp_gain_sel,
	output logic                 fifo_fill_enable,
	output logic                 burst_active
);

	typedef enum logic [1:0] {
		BURST_IDLE = 2'b00,
		BURST_WAIT = 2'b01,
		BURST_RUN  = 2'b10
	} bet_burst_phase_type;

	typedef struct packed {
		bet_burst_phase_type phase;
		logic [15:0]         wait_cnt;
		logic                wait_first;
		logic [1:0]          start;
		logic [5:0]          cnt_first;
		logic [5:0]          cnt_second;
		logic [7:0]          dead;
		logic [2:0]          mode;
		logic [7:0]          deglitch;
		logic [7:0]          ctl;
		logic [7:0]          blank;
		logic [15:0]         on_first;
		logic [15:0]         off_first;
		logic [15:0]         on_second;
		logic [15:0]         off_second;
		logic                sat_run;
		logic                sat_done;
		logic [7:0]          sat_pre;
		logic [7:0]          sat_cnt;
		logic [7:0]          sat_time;
		logic [4:0]          deg_pre;
		logic [7:0]          deg_cnt;
		logic                echo_run;
		logic                fill;
		logic [7:0]          blank_pre;
		logic [7:0]          blank_cnt;
		logic [3:0]          frt_pre;
		logic [15:0]         running_timer_shadow;
		logic [15:0]         shadow;
		logic [1:0][4:0]     flt_cnt;
		logic [1:0]          fault;
		logic [4:0]          sync1;
		logic [4:0]          sync2;
		logic [7:0]          rdata;
	} bet_state_type;

	bet_state_type     st;
	bet_state_type     next_st;
	bet_pulse_cfg_type pulse_cfg [2];
	logic [1:0]        busy;
	logic [1:0]        drive;
	logic              below;
	logic [1:0]        gate_high;
	logic [1:0]        drain_high;
	logic [4:0]        flt_limit;

	// Second stage only; first stage feeds nothing else
	assign below      = st.sync2[4];
	assign drain_high = st.sync2[3:2];
	assign gate_high  = st.sync2[1:0];
	assign flt_limit  = st.ctl[CTL_FAULT_TSEL] ?
		5'(CYC_FAULT_LONG - 1) : 5'(CYC_FAULT_SHORT - 1);

	assign pulse_cfg[0] = {st.cnt_first, st.on_first, st.off_first, st.dead};
	assign pulse_cfg[1] = {st.cnt_second, st.on_second, st.off_second, st.dead};

	// Timing is read live, so rewriting it mid-burst bends the running pulse train
	for (genvar i = 0; i < 2; i++) begin : g_chan
		bet_pulser u_pulser (
			.clk   (clk),
			.rst   (rst),
			.start (st.start[i]),
			.cfg   (pulse_cfg[i]),
			.drive (drive[i]),
			.busy  (busy[i])
		);
	end

	always_comb begin
		logic [1:0] fault_set;
		logic [1:0] fault_clr;
		logic       sat_set;
		logic       sat_clr;
		fault_set = 2'b00;
		fault_clr = 2'b00;
		sat_set   = 1'b0;
		sat_clr   = 1'b0;
		next_st       = st;
		next_st.start = 2'b00;
		next_st.sync1 = {limiter_envelope_pin, drain_above_limit, gate_above_limit};
		next_st.sync2 = st.sync1;

		// Free-running microsecond timer
		if (st.frt_pre == 4'(CYC_1US - 1)) begin
			next_st.frt_pre = 4'h0;
			next_st.running_timer_shadow     = st.running_timer_shadow + 16'h0001;
		end else begin
			next_st.frt_pre = st.frt_pre + 4'h1;
		end

		// Burst sequencing across the two channels
		unique case (st.phase)
			BURST_IDLE: begin
				next_st.wait_first = 1'b0;
			end
			BURST_WAIT: begin
				if (st.wait_cnt != 16'h0000) begin
					next_st.wait_cnt = st.wait_cnt - 16'h0001;
				end else if (!st.wait_first || !busy[0]) begin
					next_st.start[1] = 1'b1;
					next_st.phase    = BURST_RUN;
				end
			end
			BURST_RUN: begin
				if (st.start == 2'b00 && busy == 2'b00) begin
					next_st.phase = BURST_IDLE;
				end
			end
			default: begin
				next_st.phase = BURST_IDLE;
			end
		endcase

		// Saturation measurement
		if (st.sat_run) begin
			if (st.sat_pre == 8'(CYC_16US - 1)) begin
				next_st.sat_pre = 8'h00;
				if (st.sat_cnt != 8'hff) begin
					next_st.sat_cnt = st.sat_cnt + 8'h01;
				end
			end else begin
				next_st.sat_pre = st.sat_pre + 8'h01;
			end
			// A rise above threshold restarts the deglitch, so ringing cannot end it early
			if (below) begin
				if (st.deg_cnt >= st.deglitch) begin
					sat_set          = 1'b1;
					next_st.sat_time = st.sat_cnt;
					next_st.sat_run  = 1'b0;
				end else if (st.deg_pre == 5'(CYC_2US - 1)) begin
					next_st.deg_pre = 5'h00;
					next_st.deg_cnt = st.deg_cnt + 8'h01;
				end else begin
					next_st.deg_pre = st.deg_pre + 5'h01;
				end
			end else begin
				next_st.deg_pre = 5'h00;
				next_st.deg_cnt = 8'h00;
			end
		end

		// Echo blanking
		if (st.echo_run && !st.fill) begin
			if (st.blank_cnt >= st.blank) begin
				next_st.fill = 1'b1;
			end else if (st.blank_pre == 8'(CYC_16US - 1)) begin
				next_st.blank_pre = 8'h00;
				next_st.blank_cnt = st.blank_cnt + 8'h01;
			end else begin
				next_st.blank_pre = st.blank_pre + 8'h01;
			end
		end

		// Driver fault qualification per channel
		for (int i = 0; i < 2; i++) begin
			if (st.ctl[CTL_FAULT_EN] && gate_high[i] && drain_high[i]) begin
				if (st.flt_cnt[i] == flt_limit) begin
					fault_set[i] = 1'b1;
				end else begin
					next_st.flt_cnt[i] = st.flt_cnt[i] + 5'h01;
				end
			end else begin
				next_st.flt_cnt[i] = 5'h00;
			end
		end

		// Register writes
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				ADDR_ON_FIRST_HI:   next_st.on_first[15:8]   = sfr_req.wdata;
				ADDR_ON_FIRST_LO:   next_st.on_first[7:0]    = sfr_req.wdata;
				ADDR_OFF_FIRST_HI:  next_st.off_first[15:8]  = sfr_req.wdata;
				ADDR_OFF_FIRST_LO:  next_st.off_first[7:0]   = sfr_req.wdata;
				ADDR_ON_SECOND_HI:  next_st.on_second[15:8]  = sfr_req.wdata;
				ADDR_ON_SECOND_LO:  next_st.on_second[7:0]   = sfr_req.wdata;
				ADDR_OFF_SECOND_HI: next_st.off_second[15:8] = sfr_req.wdata;
				ADDR_OFF_SECOND_LO: next_st.off_second[7:0]  = sfr_req.wdata;
				ADDR_PULSE_FIRST:   next_st.cnt_first        = sfr_req.wdata[5:0];
				ADDR_PULSE_SECOND:  next_st.cnt_second       = sfr_req.wdata[5:0];
				ADDR_DEAD_TIME:     next_st.dead             = sfr_req.wdata;
				ADDR_BURST_MODE:    next_st.mode             = sfr_req.wdata[2:0];
				ADDR_SAT_DEGLITCH:  next_st.deglitch         = sfr_req.wdata;
				ADDR_RX_FAULT_CTRL: next_st.ctl              = {2'b00, sfr_req.wdata[5:0]};
				ADDR_BLANKING:      next_st.blank            = sfr_req.wdata;
				ADDR_STATUS_SECOND: begin
					sat_clr   = sfr_req.wdata[STAT_SAT_DONE];
					fault_clr = sfr_req.wdata[STAT_FAULT_FIRST +: 2];
				end
				ADDR_ENABLE_CTRL: begin
					// A start while a burst runs is dropped rather than restarting mid-pulse
					if (sfr_req.wdata[EN_BURST] && st.phase == BURST_IDLE) begin
						unique case (st.mode)
							MODE_FIRST_ONLY: begin
								next_st.start = 2'b01;
								next_st.phase = BURST_RUN;
							end
							MODE_SECOND_ONLY: begin
								next_st.start = 2'b10;
								next_st.phase = BURST_RUN;
							end
							MODE_PARALLEL: begin
								next_st.start = 2'b11;
								next_st.phase = BURST_RUN;
							end
							MODE_PUSH_PULL: begin
								// Second starts one on time after the first, a dead time after the first high interval ends
								next_st.start    = 2'b01;
								next_st.phase    = BURST_WAIT;
								next_st.wait_cnt = (st.on_first == 16'h0000) ?
									16'h0000 : st.on_first - 16'h0001;
							end
							MODE_SEQUENCE: begin
								next_st.start      = 2'b01;
								next_st.phase      = BURST_WAIT;
								next_st.wait_cnt   = 16'h0001;
								next_st.wait_first = 1'b1;
							end
							default: begin
								next_st.phase = BURST_IDLE;
							end
						endcase
					end
					if (sfr_req.wdata[EN_ECHO]) begin
						if (!st.echo_run) begin
							next_st.echo_run  = 1'b1;
							next_st.fill      = 1'b0;
							next_st.blank_pre = 8'h00;
							next_st.blank_cnt = 8'h00;
						end
					end else begin
						next_st.echo_run = 1'b0;
						next_st.fill     = 1'b0;
					end
					if (sfr_req.wdata[EN_SAT]) begin
						next_st.sat_run = 1'b1;
						next_st.sat_pre = 8'h00;
						next_st.sat_cnt = 8'h00;
						next_st.deg_pre = 5'h00;
						next_st.deg_cnt = 8'h00;
						sat_clr         = 1'b1;
						sat_set         = 1'b0;
					end else begin
						next_st.sat_run = 1'b0;
					end
					if (sfr_req.wdata[EN_CAPTURE]) begin
						next_st.shadow = st.running_timer_shadow;
					end
				end
				default: begin
					next_st.rdata = st.rdata;
				end
			endcase
		end

		// Hardware set wins over a status clear in the same cycle; a saturation enable write clears sat_done outright
		next_st.sat_done = (st.sat_done & ~sat_clr) | sat_set;
		next_st.fault    = (st.fault & ~fault_clr) | fault_set;

		// Registered read data, zero for unmapped offsets
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				ADDR_ON_FIRST_HI:   next_st.rdata = st.on_first[15:8];
				ADDR_ON_FIRST_LO:   next_st.rdata = st.on_first[7:0];
				ADDR_OFF_FIRST_HI:  next_st.rdata = st.off_first[15:8];
				ADDR_OFF_FIRST_LO:  next_st.rdata = st.off_first[7:0];
				ADDR_ON_SECOND_HI:  next_st.rdata = st.on_second[15:8];
				ADDR_ON_SECOND_LO:  next_st.rdata = st.on_second[7:0];
				ADDR_OFF_SECOND_HI: next_st.rdata = st.off_second[15:8];
				ADDR_OFF_SECOND_LO: next_st.rdata = st.off_second[7:0];
				ADDR_PULSE_FIRST:   next_st.rdata = {2'b00, st.cnt_first};
				ADDR_PULSE_SECOND:  next_st.rdata = {2'b00, st.cnt_second};
				ADDR_DEAD_TIME:     next_st.rdata = st.dead;
				ADDR_BURST_MODE:    next_st.rdata = {5'h00, st.mode};
				ADDR_SAT_DEGLITCH:  next_st.rdata = st.deglitch;
				ADDR_SAT_TIME:      next_st.rdata = st.sat_time;
				ADDR_RX_FAULT_CTRL: next_st.rdata = st.ctl;
				ADDR_BLANKING:      next_st.rdata = st.blank;
				ADDR_TIMER_HI:      next_st.rdata = st.shadow[15:8];
				ADDR_TIMER_LO:      next_st.rdata = st.shadow[7:0];
				ADDR_STATUS_SECOND: next_st.rdata = {5'h00, st.fault, st.sat_done};
				ADDR_ENABLE_CTRL:   next_st.rdata = {5'h00, st.sat_run, st.echo_run,
					st.phase != BURST_IDLE};
				default:            next_st.rdata = REG_RESET;
			endcase
		end
	end

	// All fields reset to zero, matching every register reset value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Burst start does not check active support; software orders that itself
	assign drive_output_first       = drive[0];
	assign drive_output_second      = drive[1];
	assign saturation_threshold_sel = st.ctl[CTL_SAT_SEL_LSB +: 2];
	assign amp_gain_sel             = st.ctl[CTL_GAIN_LSB +: 2];
	assign fifo_fill_enable         = st.fill;
	assign burst_active             = (st.phase != BURST_IDLE);
	assign sfr_rdata                = st.rdata;

endmodule

/* File: bet_burst_echo_timing_properties.sv */
// Port-level checks for the burst, echo and timing control block
`timescale 1ns/1ns
module bet_burst_echo_timing_properties import bet_pkg::*; (
	input wire logic            clk,
	input wire logic            rst,
	input wire bet_sfr_req_type sfr_req,
	input wire logic [7:0]      sfr_rdata,
	input wire logic            limiter_envelope_pin,
	input wire logic [1:0]      gate_above_limit,
	input wire logic [1:0]      drain_above_limit,
	input wire logic            drive_output_first,
	input wire logic            drive_output_second,
	input wire logic [1:0]      saturation_threshold_sel,
	input wire logic [1:0]      amp_gain_sel,
	input wire logic            fifo_fill_enable,
	input wire logic            burst_active
);
	typedef struct packed {
		logic [2:0]  mode;
		logic [7:0]  blank;
		logic        echo;
		logic [15:0] since;
	} bet_chk_type;
	bet_chk_type st;
	bet_chk_type next_st;
	logic        en_wr;
	logic        start;
	logic [15:0] wait_cyc;
	assign en_wr = sfr_req.wr && sfr_req.addr == ADDR_ENABLE_CTRL;
	assign start = en_wr && sfr_req.wdata[EN_BURST] && !burst_active;
	assign wait_cyc = {8'h00, st.blank} * 16'd160;
	// Shadow of mode, blanking and echo state, seen only through bus writes
	always_comb begin
		next_st = st;
		if (st.since != 16'hffff) next_st.since = st.since + 16'h0001;
		if (sfr_req.wr && sfr_req.addr == ADDR_BURST_MODE) next_st.mode = sfr_req.wdata[2:0];
		if (sfr_req.wr && sfr_req.addr == ADDR_BLANKING) next_st.blank = sfr_req.wdata;
		if (en_wr) next_st.echo = sfr_req.wdata[EN_ECHO];
		if (en_wr && sfr_req.wdata[EN_ECHO] && !st.echo) next_st.since = 16'h0000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) st <= '0;
		else st <= next_st;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_burst_start: assert property (start && st.mode < 3'h5 |=> burst_active)
		else $error("burst did not start");
	a_bad_mode: assert property (start && st.mode > 3'h4 |=> !burst_active)
		else $error("burst started in unused mode");
	a_idle_low: assert property (!burst_active |-> !drive_output_first && !drive_output_second)
		else $error("drive high outside burst");
	a_first_after: assert property ($rose(drive_output_first)
		|-> $past(burst_active) && !$past(drive_output_second))
		else $error("first drive high without lead");
	a_second_after: assert property ($rose(drive_output_second)
		|-> $past(burst_active) && !$past(drive_output_first))
		else $error("second drive high without lead");
	a_thresh_sel: assert property (sfr_req.wr && sfr_req.addr == ADDR_RX_FAULT_CTRL
		|=> saturation_threshold_sel == $past(sfr_req.wdata[1:0]))
		else $error("threshold select wrong");
	a_gain_sel: assert property (sfr_req.wr && sfr_req.addr == ADDR_RX_FAULT_CTRL
		|=> amp_gain_sel == $past(sfr_req.wdata[3:2]))
		else $error("gain select wrong");
	a_echo_stop: assert property (en_wr && !sfr_req.wdata[EN_ECHO] |=> !fifo_fill_enable)
		else $error("fill kept after echo off");
	a_fill_wait: assert property ($rose(fifo_fill_enable) |-> st.echo && st.since > wait_cyc)
		else $error("fill before blanking elapsed");
	a_fill_due: assert property (st.echo && st.since == wait_cyc + 16'd3 |-> fifo_fill_enable)
		else $error("fill late after blanking");
	c_burst: cover property ($fell(burst_active));
	c_both: cover property (drive_output_first && drive_output_second);
	c_fill: cover property ($rose(fifo_fill_enable));
endmodule
bind bet_burst_echo_timing bet_burst_echo_timing_properties chk_i (.*);

/* File: bet_transducer_model.sv */
// Transducer, limiter envelope and low-side FET sense model
`timescale 1ns/1ns
module bet_transducer_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        drive_output_first,
	input  wire logic        drive_output_second,
	input  wire logic [15:0] settle_cycles,
	input  wire logic        fet_shorted,
	output logic             limiter_envelope_pin,
	output logic [1:0]       gate_above_limit,
	output logic [1:0]       drain_above_limit
);
	logic [15:0] ring;
	// Envelope rings on after the last pulse, so it drops only after a settle time
	always_ff @(negedge clk or posedge rst) begin
		if (rst) begin
			ring <= 16'h0000;
			limiter_envelope_pin <= 1'b0;
			gate_above_limit <= 2'b00;
			drain_above_limit <= 2'b11;
		end else begin
			if (drive_output_first || drive_output_second) ring <= 16'h0000;
			else if (ring != 16'hffff) ring <= ring + 16'h0001;
			limiter_envelope_pin <= ring >= settle_cycles;
			gate_above_limit <= {drive_output_second, drive_output_first};
			// Shorted load keeps the drain high even while the gate is on
			drain_above_limit <= fet_shorted ? 2'b11 : ~{drive_output_second, drive_output_first};
		end
	end
endmodule

/* File: test_bet_burst_echo_timing.sv */
// Self-checking bench for the burst, echo and timing control block
`timescale 1ns/1ns
module test_bet_burst_echo_timing import bet_pkg::*;;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	bet_sfr_req_type sfr_req = '0;
	logic [7:0]      sfr_rdata, v, hi, lo;
	logic            env, fill, active, d1, d2, p1, p2;
	logic            shorted = 1'b0;
	logic [15:0]     settle = 16'd460;
	logic [15:0]     s1, s2;
	logic [1:0]      gate, drain, thr, gain;
	int              error_cnt = 0, num_checks = 0, cyc = 0;
	int              rises1, rises2, t1, t2, hi_len, lo_len, hi_run, lo_run;
	logic [7:0]      regs [10] = '{ADDR_PULSE_FIRST, ADDR_PULSE_SECOND, ADDR_DEAD_TIME,
		ADDR_BURST_MODE, ADDR_SAT_DEGLITCH, ADDR_SAT_TIME, ADDR_RX_FAULT_CTRL, ADDR_BLANKING,
		ADDR_TIMER_HI, ADDR_TIMER_LO};
	logic [7:0]      masks [10] = '{8'h3f, 8'h3f, 8'hff, 8'h07, 8'hff, 8'h00, 8'h3f, 8'hff,
		8'h00, 8'h00};
	logic [7:0]      set_a [7] = '{ADDR_ON_FIRST_LO, ADDR_OFF_FIRST_LO, ADDR_ON_SECOND_LO,
		ADDR_OFF_SECOND_LO, ADDR_DEAD_TIME, ADDR_PULSE_FIRST, ADDR_PULSE_SECOND};
	logic [7:0]      set_d [7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h01, 8'h3f, 8'h02};

	always #50 clk = ~clk;

	bet_burst_echo_timing DUT (.clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.limiter_envelope_pin(env), .gate_above_limit(gate), .drain_above_limit(drain),
		.drive_output_first(d1), .drive_output_second(d2), .saturation_threshold_sel(thr),
		.amp_gain_sel(gain), .fifo_fill_enable(fill), .burst_active(active));
	bet_transducer_model xdcr (.clk(clk), .rst(rst), .drive_output_first(d1),
		.drive_output_second(d2), .settle_cycles(settle), .fet_shorted(shorted),
		.limiter_envelope_pin(env), .gate_above_limit(gate), .drain_above_limit(drain));

	// Pulse edges and widths, sampled where outputs have settled
	always @(negedge clk) begin
		cyc++;
		if (d1 && !p1) begin
			rises1++;
			if (rises1 == 1) t1 = cyc;
			lo_len = lo_run;
			hi_run = 0;
		end
		if (!d1 && p1) begin
			hi_len = hi_run;
			lo_run = 0;
		end
		if (d2 && !p2) begin
			rises2++;
			if (rises2 == 1) t2 = cyc;
		end
		hi_run++;
		lo_run++;
		p1 = d1;
		p2 = d2;
		// Last in the block, so nothing runs after the closing report
		if (cyc > 20000) begin
			error_cnt++;
			results();
		end
	end

	// Idle cycle first, so a strobe never falls and rises in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_req.addr = a;
		sfr_req.wdata = d;
		sfr_req.wr = 1'b1;
		@(negedge clk);
		sfr_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_req.addr = a;
		sfr_req.rd = 1'b1;
		@(negedge clk);
		sfr_req.rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_idle;
		int n = 0;
		while (active !== 1'b0 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk("burst end", 16'h0000, {15'h0, active});
	endtask
	task automatic results;
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		wr(8'hc3, 8'h01);
		rd(8'hc3, v);
		chk("unmapped", 16'h0000, {8'h00, v});
		for (int i = 0; i < 10; i++) begin
			rd(regs[i], v);
			chk("reset value", 16'h0000, {8'h00, v});
			wr(regs[i], 8'hff);
			rd(regs[i], v);
			chk("readback", {8'h00, masks[i]}, {8'h00, v});
		end
		for (int i = 0; i < 7; i++) wr(set_a[i], set_d[i]);
		for (int m = 0; m < 6; m++) begin
			wr(ADDR_BURST_MODE, m[7:0]);
			rises1 = 0;
			rises2 = 0;
			wr(ADDR_ENABLE_CTRL, 8'h01);
			// Second start while busy must add no pulses
			wr(ADDR_ENABLE_CTRL, 8'h01);
			wait_idle();
			chk("pulses first", (m == 0 || (m > 1 && m < 5)) ? 16'd63 : 16'd0, rises1[15:0]);
			chk("pulses second", (m > 0 && m < 5) ? 16'd2 : 16'd0, rises2[15:0]);
			if (m == 2) chk("push-pull lag", 16'd4, 16'(t2 - t1));
			if (m == 3) chk("parallel lag", 16'd0, 16'(t2 - t1));
			if (m == 4) chk("sequence", 16'd1, {15'h0, t2 - t1 > 499});
		end
		chk("high time", 16'd3, hi_len[15:0]);
		chk("low time", 16'd5, lo_len[15:0]);
		wr(ADDR_PULSE_FIRST, 8'h00);
		wr(ADDR_BURST_MODE, 8'h00);
		rises1 = 0;
		wr(ADDR_ENABLE_CTRL, 8'h01);
		wait_idle();
		chk("zero count", 16'd0, rises1[15:0]);
		// Expiry near cycle 545 from enable: 3 whole 16 us ticks
		wr(ADDR_PULSE_FIRST, 8'h03);
		wr(ADDR_SAT_DEGLITCH, 8'h03);
		wr(ADDR_STATUS_SECOND, 8'hff);
		wr(ADDR_ENABLE_CTRL, 8'h05);
		repeat (300) @(negedge clk);
		rd(ADDR_STATUS_SECOND, v);
		chk("done early", 16'd0, {15'h0, v[STAT_SAT_DONE]});
		repeat (400) @(negedge clk);
		rd(ADDR_STATUS_SECOND, v);
		chk("sat done", 16'd1, {15'h0, v[STAT_SAT_DONE]});
		rd(ADDR_SAT_TIME, v);
		chk("sat time", 16'd3, {8'h00, v});
		// High lasts 15 cycles: beyond 1 us, short of 2 us
		wr(ADDR_ON_FIRST_LO, 8'h10);
		wr(ADDR_PULSE_FIRST, 8'h01);
		wr(ADDR_STATUS_SECOND, 8'hff);
		shorted <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_RX_FAULT_CTRL, s ? 8'h36 : 8'h16);
			chk("threshold and gain", 16'h0009, {12'h000, thr, gain});
			wr(ADDR_ENABLE_CTRL, 8'h01);
			wait_idle();
			rd(ADDR_STATUS_SECOND, v);
			chk("fault flag", s ? 16'd0 : 16'd1, {15'h0, v[STAT_FAULT_FIRST]});
			wr(ADDR_STATUS_SECOND, 8'hff);
		end
		shorted <= 1'b0;
		wr(ADDR_BLANKING, 8'h02);
		wr(ADDR_ENABLE_CTRL, 8'h02);
		repeat (300) @(negedge clk);
		chk("fill early", 16'd0, {15'h0, fill});
		repeat (40) @(negedge clk);
		chk("fill on", 16'd1, {15'h0, fill});
		wr(ADDR_ENABLE_CTRL, 8'h00);
		@(negedge clk);
		chk("fill off", 16'd0, {15'h0, fill});
		// Two captures exactly 1010 cycles apart
		wr(ADDR_ENABLE_CTRL, 8'h08);
		rd(ADDR_TIMER_HI, hi);
		rd(ADDR_TIMER_LO, lo);
		s1 = {hi, lo};
		repeat (1000) @(negedge clk);
		rd(ADDR_TIMER_HI, hi);
		rd(ADDR_TIMER_LO, lo);
		chk("shadow held", s1, {hi, lo});
		wr(ADDR_ENABLE_CTRL, 8'h08);
		rd(ADDR_TIMER_HI, hi);
		rd(ADDR_TIMER_LO, lo);
		s2 = {hi, lo};
		chk("timer step", 16'd101, s2 - s1);
		results();
	end
endmodule
